//--- dv/tb_profiling_capability_and_user_record.sv
`timescale 1ns/10ps
module tb_profiling_capability_and_user_record;
    // ==========================================================
    // stimulus and design
    // ==========================================================
    logic         clk = 1'b0, rst = 1'b1, ins_valid = 1'b0;
    logic         record_ready = 1'b1, query_valid = 1'b0;
    logic         legacy_mode = 1'b0, timestamp_enable_flag = 1'b0;
    logic         ins_ready, record_valid, result_valid;
    logic [15:0]  ins_flags = 16'h0;
    logic [31:0]  ins_first_data = 32'h0, other_enabled_size = 32'h0;
    logic [63:0]  ins_address = 64'h0, ins_reg_value = 64'h0;
    logic [63:0]  timestamp_counter = 64'h0, feature_enable_reg = 64'h0;
    logic [7:0]   cpu_identifier = 8'h0;
    logic [31:1]  config_avail_bits = 31'h0;
    logic [31:0]  query_leaf = 32'h0, query_subleaf = 32'h0;
    logic [31:0]  result_eax, result_ebx, result_ecx, result_edx, oth;
    logic [255:0] record_data, exp_rec;
    logic         en;
    integer       seed = 32'h47DC9B23, error_cnt = 0, comparisons = 0;
    integer       cyc = 0, n;

    profiling_capability_and_user_record profiling_capability_and_user_record_i (
        .clk(clk), .rst(rst), .ins_valid(ins_valid), .ins_ready(ins_ready),
        .ins_flags(ins_flags), .ins_first_data(ins_first_data),
        .ins_address(ins_address), .ins_reg_value(ins_reg_value),
        .legacy_mode(legacy_mode),
        .timestamp_enable_flag(timestamp_enable_flag),
        .timestamp_counter(timestamp_counter),
        .cpu_identifier(cpu_identifier),
        .config_avail_bits(config_avail_bits),
        .feature_enable_reg(feature_enable_reg),
        .other_enabled_size(other_enabled_size),
        .record_valid(record_valid), .record_ready(record_ready),
        .record_data(record_data), .query_valid(query_valid),
        .query_leaf(query_leaf), .query_subleaf(query_subleaf),
        .result_valid(result_valid), .result_eax(result_eax),
        .result_ebx(result_ebx), .result_ecx(result_ecx),
        .result_edx(result_edx));

    // clock and hang guard
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            error_cnt = error_cnt + 1;
            complete_run();
        end
    end

    // ==========================================================
    // shared tasks
    // ==========================================================
    task automatic chk(string nm, logic [255:0] e, logic [255:0] g);
        comparisons = comparisons + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    // expected user record from the operands now on the pins
    function automatic logic [255:0] expect_record();
        return {timestamp_enable_flag ? timestamp_counter : 64'h0,
                legacy_mode ? {32'h0, ins_reg_value[31:0]} : ins_reg_value,
                ins_address, ins_first_data, ins_flags, cpu_identifier,
                8'hFF};
    endfunction

    // one user event, back to back, ring buffer stalling at random
    task automatic send();
        ins_valid = 1'b1;
        ins_flags = 16'($random(seed));
        ins_first_data = $random(seed);
        ins_address = {$random(seed), $random(seed)};
        ins_reg_value = {$random(seed), $random(seed)};
        timestamp_counter = {$random(seed), $random(seed)};
        legacy_mode = 1'($random(seed));
        timestamp_enable_flag = 1'($random(seed));
        cpu_identifier = 8'($random(seed));
        record_ready = 1'($random(seed));
        #1;
        chk("ins_ready", record_ready || exp_rec == 256'h0, ins_ready);
        n = 0;
        while (ins_ready !== 1'b1 && n < 20) begin
            chk("held record", exp_rec, record_data);
            @(negedge clk);
            record_ready = 1'($random(seed));
            n = n + 1;
            #1;
        end
        exp_rec = expect_record();
        @(negedge clk);
        chk("record_valid", 1'b1, record_valid);
        chk("record", exp_rec, record_data);
    endtask

    // one idle cycle, one query strobe, answer one cycle later
    task automatic q(logic [31:0] leaf, logic [31:0] sub);
        @(negedge clk);
        chk("result_valid low", 1'b0, result_valid);
        query_valid = 1'b1;
        query_leaf = leaf;
        query_subleaf = sub;
        @(negedge clk);
        query_valid = 1'b0;
        chk("result_valid", 1'b1, result_valid);
    endtask

    task automatic complete_run();
        $display("counts: %0d compares, %0d bad", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("reset state", 131'h0, {!ins_ready, record_valid, result_valid,
            result_eax, result_ebx, result_ecx, result_edx});
        exp_rec = 256'h0;
        for (int i = 0; i < 40; i++) send();
        ins_valid = 1'b0;
        $display("test records done");
        for (int i = 0; i < 10; i++) begin
            feature_enable_reg = {$random(seed), $random(seed)};
            config_avail_bits = $random(seed);
            oth = (i < 2) ? 32'h3C0 + i : $random(seed) & 32'h7FF;
            other_enabled_size = oth;
            en = feature_enable_reg[62];
            q(32'h8000_001C, $random(seed));
            chk("avail", {config_avail_bits & 31'h7000_003F, en},
                result_eax);
            chk("geometry", 32'h8006_2016, result_ebx);
            chk("full caps", 32'hE000_007F, result_edx);
            q(32'h8000_0001, 32'h0);
            chk("ext support", 1'b1, result_ecx[15]);
            q(32'h0000_000D, 32'h0);
            chk("save support", 1'b1, result_edx[30]);
            chk("supported max", 32'h3C0, result_ecx);
            chk("enabled max", (en && oth < 32'h3C0) ? 32'h3C0 : oth,
                result_ebx);
            q(32'h0000_000D, 32'h3E);
            chk("save size", 32'h80, result_eax);
            chk("save offset", 32'h340, result_ebx);
            q(32'h0000_0003, 32'h1);
            chk("unknown", 128'h0, {result_eax, result_ebx, result_ecx,
                result_edx});
        end
        $display("test queries done");
        // reset in mid-run with a record and an answer standing
        q(32'h0000_000D, 32'h3E);
        rst = 1'b1;
        @(negedge clk);
        chk("reset record", 256'h0, record_data);
        chk("reset state", 131'h0, {!ins_ready, record_valid, result_valid,
            result_eax, result_ebx, result_ecx, result_edx});
        rst = 1'b0;
        @(negedge clk);
        q(32'h8000_0001, 32'h0);
        chk("ext after reset", 1'b1, result_ecx[15]);
        $display("test reset done");
        complete_run();
    end
endmodule

//--- hdl/profiling_capability_and_user_record.sv
`timescale 1ns/10ps
// Operation
// - user event writes record with id 255
// - byte 1 carries configured cpu identifier
// - flags immediate and first data word
// - bytes 15-8 hold instruction address
// - register operand, zero extended in legacy
// - timestamp when flag set, else zero
// - support bit mirrored in three places
// - subleaf 62 size reports 128 bytes
// - subleaf 62 offset reports 832 bytes
// - supported max always, enabled max conditionally
// - available bit mirrors enable register bit 62
// - available bits from config, subset of full
// - bits 1-6 flag event identifiers 1-6
// - bits 29-31 mode flags, 28:7 reserved
// - control block quadwords at least minimum
// - record size field reports 32 bytes
// - highest event identifier, excluding 255
// - event offset, multiple of eight
// - full capability bit 0 reports support
module profiling_capability_and_user_record #(
    parameter logic [31:0] FULL_CAPS         = profiling_pkg::CAP_FULL_RESET,
    parameter logic [7:0]  MAX_EVENT_ID      = profiling_pkg::MAX_EVENT_RESET,
    parameter logic [7:0]  EVENT_AREA_OFFSET =
        profiling_pkg::EVENT_OFFSET_RESET,
    parameter logic [7:0]  CB_QWORDS_MIN     = profiling_pkg::CB_QWORDS_RESET,
    parameter logic [31:0] OTHER_SUPPORTED_SIZE =
        profiling_pkg::OTHER_SAVE_RESET
) (
    // clock and reset
    input  wire logic                                  clk,
    input  wire logic                                  rst,
    // insert user event instruction
    input  wire logic                                  ins_valid,
    output logic                                       ins_ready,
    input  wire logic [15:0]                           ins_flags,
    input  wire logic [31:0]                           ins_first_data,
    input  wire logic [63:0]                           ins_address,
    input  wire logic [63:0]                           ins_reg_value,
    // core context
    input  wire logic                                  legacy_mode,
    input  wire logic                                  timestamp_enable_flag,
    input  wire logic [63:0]                           timestamp_counter,
    // profiling configuration register contents
    input  wire logic [7:0]                            cpu_identifier,
    input  wire logic [31:1]                           config_avail_bits,
    // extended feature enable register
    input  wire logic [63:0]                           feature_enable_reg,
    input  wire logic [31:0]                           other_enabled_size,
    // record toward the ring buffer
    output logic                                       record_valid,
    input  wire logic                                  record_ready,
    output logic [profiling_pkg::RECORD_BITS-1:0]      record_data,
    // identification query
    input  wire logic                                  query_valid,
    input  wire logic [31:0]                           query_leaf,
    input  wire logic [31:0]                           query_subleaf,
    output logic                                       result_valid,
    output logic [31:0]                                result_eax,
    output logic [31:0]                                result_ebx,
    output logic [31:0]                                result_ecx,
    output logic [31:0]                                result_edx
);

    // ==========================================================
    // user record builder
    // ==========================================================
    user_record_builder u_builder (
        .clk                   (clk),
        .rst                   (rst),
        .ins_valid             (ins_valid),
        .ins_ready             (ins_ready),
        .ins_flags             (ins_flags),
        .ins_first_data        (ins_first_data),
        .ins_address           (ins_address),
        .ins_reg_value         (ins_reg_value),
        .cpu_identifier        (cpu_identifier),
        .legacy_mode           (legacy_mode),
        .timestamp_enable_flag (timestamp_enable_flag),
        .timestamp_counter     (timestamp_counter),
        .record_valid          (record_valid),
        .record_ready          (record_ready),
        .record_data           (record_data)
    );

    // ==========================================================
    // capability and geometry words
    // ==========================================================
    typedef struct packed {
        logic        valid;
        logic [31:0] available_capability_word;
        logic [31:0] record_geometry_word;
        logic [31:0] ecx;
        logic [31:0] edx;
    } query_state_type;

    query_state_type st_q;
    query_state_type st_d;

    logic        prof_supported;
    logic        prof_enabled;
    logic [31:0] full_caps_word;
    logic [31:0] avail_caps_word;
    logic [7:0]  offset_aligned;
    logic [7:0]  cb_floor;
    logic [7:0]  cb_quadwords;
    logic [31:0] geometry_word;
    logic [31:0] supported_max;
    logic [31:0] enabled_max;

    // full capability word, reserved positions forced to zero
    always_comb begin
        full_caps_word = FULL_CAPS & profiling_pkg::CAP_DEFINED_MASK;
        prof_supported = full_caps_word[profiling_pkg::CAP_AVAIL];
    end

    // available word: enable bit plus config bits masked by full
    always_comb begin
        prof_enabled = feature_enable_reg[profiling_pkg::XCR_PROF_BIT];
        avail_caps_word = '0;
        avail_caps_word[profiling_pkg::CAP_AVAIL] = prof_enabled;
        avail_caps_word[31:1] = config_avail_bits
            & full_caps_word[31:1];
        // event ids 1..6 and mode flags keep their positions
        avail_caps_word[profiling_pkg::CAP_RNH:profiling_pkg::CAP_VAL] =
            config_avail_bits[profiling_pkg::CAP_RNH:profiling_pkg::CAP_VAL]
            & full_caps_word[profiling_pkg::CAP_RNH:profiling_pkg::CAP_VAL];
        avail_caps_word[28:7] = 22'h0;
    end

    // geometry word fields
    always_comb begin
        offset_aligned = EVENT_AREA_OFFSET
            & profiling_pkg::OFFSET_ALIGN_MASK;
        cb_floor = 8'(offset_aligned >> 3) + MAX_EVENT_ID;
        cb_quadwords = (CB_QWORDS_MIN > cb_floor)
            ? CB_QWORDS_MIN : cb_floor;
        geometry_word = '0;
        geometry_word[profiling_pkg::GEO_CB_LSB +: 8] = cb_quadwords;
        geometry_word[profiling_pkg::GEO_SIZE_LSB +: 8] =
            profiling_pkg::RECORD_SIZE_BYTES;
        geometry_word[profiling_pkg::GEO_MAX_LSB +: 8] = MAX_EVENT_ID;
        geometry_word[profiling_pkg::GEO_OFFSET_LSB +: 8] =
            offset_aligned;
    end

    // save area maxima
    always_comb begin
        supported_max = (OTHER_SUPPORTED_SIZE > profiling_pkg::SAVE_AREA_END)
            ? OTHER_SUPPORTED_SIZE : profiling_pkg::SAVE_AREA_END;
        if (prof_enabled
            && other_enabled_size < profiling_pkg::SAVE_AREA_END) begin
            enabled_max = profiling_pkg::SAVE_AREA_END;
        end else begin
            enabled_max = other_enabled_size;
        end
    end

    // query decode; answers stand until the next query
    always_comb begin
        st_d = st_q;
        st_d.valid = query_valid;
        if (query_valid) begin
            st_d.available_capability_word = profiling_pkg::RESULT_ZERO;
            st_d.record_geometry_word = profiling_pkg::RESULT_ZERO;
            st_d.ecx = profiling_pkg::RESULT_ZERO;
            st_d.edx = profiling_pkg::RESULT_ZERO;
            case (query_leaf)
                profiling_pkg::LEAF_EXT_FEATURES: begin
                    st_d.ecx[profiling_pkg::EXT_ECX_PROF_BIT] =
                        prof_supported;
                end
                profiling_pkg::LEAF_SAVE_STATE: begin
                    if (query_subleaf == profiling_pkg::SUBLEAF_MAIN) begin
                        st_d.record_geometry_word = enabled_max;
                        st_d.ecx = supported_max;
                        st_d.edx[profiling_pkg::SAVE_EDX_PROF_BIT] =
                            prof_supported;
                    end else if (query_subleaf ==
                                 profiling_pkg::SUBLEAF_PROFILING) begin
                        st_d.available_capability_word = profiling_pkg::SAVE_AREA_SIZE;
                        st_d.record_geometry_word = profiling_pkg::SAVE_AREA_OFFSET;
                    end
                end
                profiling_pkg::LEAF_PROFILING: begin
                    st_d.available_capability_word = avail_caps_word;
                    st_d.record_geometry_word = geometry_word;
                    st_d.edx = full_caps_word;
                end
                default: begin
                    st_d.available_capability_word = profiling_pkg::RESULT_ZERO;
                end
            endcase
        end
    end

    // query state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign result_valid = st_q.valid;
    assign result_eax   = st_q.available_capability_word;
    assign result_ebx   = st_q.record_geometry_word;
    assign result_ecx   = st_q.ecx;
    assign result_edx   = st_q.edx;

    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb_main @(posedge clk);
    endclocking
    default disable iff (rst);

    // helpers: previous query kind
    logic q_cap;
    logic q_sub62;
    logic q_main;
    logic q_ext;
    assign q_cap   = query_valid
        && query_leaf == profiling_pkg::LEAF_PROFILING;
    assign q_sub62 = query_valid
        && query_leaf == profiling_pkg::LEAF_SAVE_STATE
        && query_subleaf == profiling_pkg::SUBLEAF_PROFILING;
    assign q_main  = query_valid
        && query_leaf == profiling_pkg::LEAF_SAVE_STATE
        && query_subleaf == profiling_pkg::SUBLEAF_MAIN;
    assign q_ext   = query_valid
        && query_leaf == profiling_pkg::LEAF_EXT_FEATURES;

    a_record_event_id: assert property (
        ins_valid && ins_ready |=> record_valid
            && record_data[7:0] == 8'hFF)
        else $error("user record id or valid wrong");

    a_record_cpu_id: assert property (
        ins_valid && ins_ready |=>
            record_data[15:8] == $past(cpu_identifier))
        else $error("cpu identifier not in byte 1");

    a_record_flags_data: assert property (
        ins_valid && ins_ready |=>
            record_data[31:16] == $past(ins_flags)
            && record_data[63:32] == $past(ins_first_data))
        else $error("flags or first data word wrong");

    a_record_address: assert property (
        ins_valid && ins_ready |=>
            record_data[127:64] == $past(ins_address))
        else $error("instruction address wrong");

    a_record_legacy_ext: assert property (
        ins_valid && ins_ready && legacy_mode |=>
            record_data[191:160] == 32'h0000_0000
            && record_data[159:128] == $past(ins_reg_value[31:0]))
        else $error("legacy second data word not zero extended");

    a_record_stamp_off: assert property (
        ins_valid && ins_ready && !timestamp_enable_flag |=>
            record_data[255:192] == 64'h0)
        else $error("timestamp present while flag clear");

    a_record_stamp_on: assert property (
        ins_valid && ins_ready && timestamp_enable_flag |=>
            record_data[255:192] == $past(timestamp_counter))
        else $error("timestamp missing while flag set");

    a_record_native: assert property (
        ins_valid && ins_ready && !legacy_mode |=>
            record_data[191:128] == $past(ins_reg_value))
        else $error("second data word not copied");

    a_ready_refused: assert property (
        record_valid && !record_ready |-> !ins_ready)
        else $error("new record accepted over a held one");

    a_record_hold: assert property (
        record_valid && !record_ready |=> record_valid
            && $stable(record_data))
        else $error("record changed before it was taken");

    a_ext_support: assert property (
        q_ext |=> result_valid && result_ecx[15] == FULL_CAPS[0])
        else $error("extended feature support bit wrong");

    a_save_area_geom: assert property (
        q_sub62 |=> result_eax == 32'h0000_0080
            && result_ebx == 32'h0000_0340)
        else $error("save area size or offset wrong");

    a_enabled_max: assert property (
        q_main && feature_enable_reg[62] |=> result_ebx >= 32'h0000_03C0
            && result_ecx >= 32'h0000_03C0)
        else $error("save maxima omit profiling area");

    a_enabled_max_off: assert property (
        q_main && !feature_enable_reg[62] |=>
            result_ebx == $past(other_enabled_size))
        else $error("enabled maximum includes disabled area");

    a_save_support: assert property (
        q_main |=> result_edx[30] == FULL_CAPS[0])
        else $error("save leaf support bit wrong");

    a_avail_mirror: assert property (
        q_cap |=> result_eax[0] == $past(feature_enable_reg[62]))
        else $error("available bit does not mirror enable");

    a_avail_subset: assert property (
        q_cap |=> (result_eax[31:1] & ~result_edx[31:1]) == 31'h0)
        else $error("available bits exceed full capabilities");

    a_reserved_zero: assert property (
        q_cap |=> result_eax[28:7] == 22'h0
            && result_edx[28:7] == 22'h0)
        else $error("reserved capability bits set");

    a_geometry_fields: assert property (
        q_cap |=> result_ebx[15:8] == 8'h20
            && result_ebx[26:24] == 3'h0
            && result_ebx[7:0] >= 8'(result_ebx[31:27])
                + result_ebx[23:16])
        else $error("geometry word fields wrong");

    a_result_pulse: assert property (
        result_valid && !$past(query_valid) |-> 1'b0)
        else $error("answer without query");

    a_result_follows: assert property (
        query_valid |=> result_valid)
        else $error("query left without answer");

    c_user_record: cover property (
        ins_valid && ins_ready ##1 record_valid && record_ready);
    c_record_stall: cover property (
        record_valid && !record_ready [*2]);
    c_cap_query: cover property (q_cap ##1 result_valid);
    c_save_query: cover property (q_sub62 ##1 result_valid);
    c_main_query: cover property (q_main ##1 result_valid);

endmodule

//--- hdl/profiling_pkg.sv
package profiling_pkg;

    // ==========================================================
    // user-inserted record layout
    // ==========================================================
    localparam int          RECORD_BITS      = 256;
    localparam logic [7:0]  USER_EVENT_ID    = 8'hFF;
    localparam logic [7:0]  RECORD_SIZE_BYTES = 8'h20;
    localparam int          REC_ID_LSB       = 0;
    localparam int          REC_CPU_LSB      = 8;
    localparam int          REC_FLAGS_LSB    = 16;
    localparam int          REC_FIRST_DATA_WORD_LSB    = 32;
    localparam int          REC_ADDR_LSB     = 64;
    localparam int          REC_SECOND_DATA_WORD_LSB    = 128;
    localparam int          REC_TS_LSB       = 192;
    localparam logic [31:0] LEGACY_UPPER_ZERO = 32'h0000_0000;

    // ==========================================================
    // identification query leaves
    // ==========================================================
    localparam logic [31:0] LEAF_EXT_FEATURES = 32'h8000_0001;
    localparam logic [31:0] LEAF_SAVE_STATE   = 32'h0000_000D;
    localparam logic [31:0] LEAF_PROFILING    = 32'h8000_001C;
    localparam logic [31:0] SUBLEAF_MAIN      = 32'h0000_0000;
    localparam logic [31:0] SUBLEAF_PROFILING = 32'h0000_003E;
    localparam logic [31:0] RESULT_ZERO       = 32'h0000_0000;

    // ==========================================================
    // feature bit positions
    // ==========================================================
    localparam int EXT_ECX_PROF_BIT  = 15;
    localparam int SAVE_EDX_PROF_BIT = 30;
    localparam int XCR_PROF_BIT      = 62;

    // ==========================================================
    // save area geometry, in bytes
    // ==========================================================
    localparam logic [31:0] SAVE_AREA_SIZE   = 32'h0000_0080;
    localparam logic [31:0] SAVE_AREA_OFFSET = 32'h0000_0340;
    localparam logic [31:0] SAVE_AREA_END    =
        SAVE_AREA_OFFSET + SAVE_AREA_SIZE;

    // ==========================================================
    // capability word bits
    // ==========================================================
    localparam int CAP_AVAIL = 0;
    localparam int CAP_VAL   = 1;
    localparam int CAP_IRE   = 2;
    localparam int CAP_BRE   = 3;
    localparam int CAP_DME   = 4;
    localparam int CAP_CNH   = 5;
    localparam int CAP_RNH   = 6;
    localparam int CAP_CONT  = 29;
    localparam int CAP_TS    = 30;
    localparam int CAP_INT   = 31;
    localparam logic [31:0] CAP_DEFINED_MASK = 32'hE000_007F;
    localparam logic [31:0] CAP_FULL_RESET   = 32'hE000_007F;

    // ==========================================================
    // geometry word fields
    // ==========================================================
    localparam int GEO_CB_LSB     = 0;
    localparam int GEO_SIZE_LSB   = 8;
    localparam int GEO_MAX_LSB    = 16;
    localparam int GEO_OFFSET_LSB = 24;
    localparam logic [7:0] OFFSET_ALIGN_MASK = 8'hF8;
    localparam logic [7:0] MAX_EVENT_RESET   = 8'h06;
    localparam logic [7:0] EVENT_OFFSET_RESET = 8'h80;
    localparam logic [7:0] CB_QWORDS_RESET   = 8'h00;
    localparam logic [31:0] OTHER_SAVE_RESET = 32'h0000_0240;

endpackage

//--- hdl/user_record_builder.sv
`timescale 1ns/10ps
module user_record_builder (
    // clock and reset
    input  wire logic                                    clk,
    input  wire logic                                    rst,
    // instruction operands
    input  wire logic                                    ins_valid,
    output logic                                         ins_ready,
    input  wire logic [15:0]                             ins_flags,
    input  wire logic [31:0]                             ins_first_data,
    input  wire logic [63:0]                             ins_address,
    input  wire logic [63:0]                             ins_reg_value,
    // core context
    input  wire logic [7:0]                              cpu_identifier,
    input  wire logic                                    legacy_mode,
    input  wire logic                                    timestamp_enable_flag,
    input  wire logic [63:0]                             timestamp_counter,
    // record toward the ring buffer
    output logic                                         record_valid,
    input  wire logic                                    record_ready,
    output logic [profiling_pkg::RECORD_BITS-1:0]        record_data
);

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        logic                                 valid;
        logic [profiling_pkg::RECORD_BITS-1:0] data;
    } builder_state_type;

    builder_state_type st_q;
    builder_state_type st_d;
    logic [63:0]       second_word;
    logic [63:0]       stamp;

    // accept a new record when empty or when the held one drains
    assign ins_ready = !st_q.valid || record_ready;

    // operand shaping
    always_comb begin
        second_word = legacy_mode
            ? {profiling_pkg::LEGACY_UPPER_ZERO, ins_reg_value[31:0]}
            : ins_reg_value;
        stamp = timestamp_enable_flag ? timestamp_counter : 64'h0;
    end

    // next state: hold until taken, then load the next record
    always_comb begin
        st_d = st_q;
        if (st_q.valid && record_ready) begin
            st_d.valid = 1'b0;
        end
        if (ins_valid && ins_ready) begin
            st_d.valid = 1'b1;
            st_d.data = '0;
            st_d.data[profiling_pkg::REC_ID_LSB +: 8] =
                profiling_pkg::USER_EVENT_ID;
            st_d.data[profiling_pkg::REC_CPU_LSB +: 8] = cpu_identifier;
            st_d.data[profiling_pkg::REC_FLAGS_LSB +: 16] = ins_flags;
            st_d.data[profiling_pkg::REC_FIRST_DATA_WORD_LSB +: 32] =
                ins_first_data;
            st_d.data[profiling_pkg::REC_ADDR_LSB +: 64] = ins_address;
            st_d.data[profiling_pkg::REC_SECOND_DATA_WORD_LSB +: 64] = second_word;
            st_d.data[profiling_pkg::REC_TS_LSB +: 64] = stamp;
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign record_valid = st_q.valid;
    assign record_data  = st_q.data;

endmodule
